// ### pscl_loader.sv
// Behaviour
// - data sampled on bit-clock rising edge
// - load complete ends loading, waits for edges
// - two falling edges start initialisation
// - init-complete rises on entering user mode
// - user mode releases weak I/O pull-ups
// - compressed stream expanded into config memory
// - expansion outruns serial delivery, stalls while memory not ready
// - chain enable high while loading own image
// - after load, chain enable low, forward
// - cable mode ignores user start-up clock
// - flash write alone never reconfigures
// - reconfig pulse resets loader, reloads all
module pscl_loader
   import pscl_pkg::*;
#(
   parameter int IMAGE_BYTES = IMAGE_BYTES_DEF,
   parameter int INIT_TICKS  = INIT_TICKS_DEF,
   parameter int BUF_W       = 8,
   parameter int BUF_DEPTH   = 2
) (
   input  wire logic           clk,
   input  wire logic           resetn,
   input  wire logic           configRequestN,
   output logic                configStatusN,
   input  wire logic           configBitClock,
   input  wire logic           configData,
   output logic                loadComplete,
   output logic                initDone,
   output logic                weakPullupEn,
   input  wire logic           chainEnableInN,
   output logic                chainEnableOutN,
   output logic                chainData,
   input  wire logic           userStartupClock,
   input  wire logic           useStartupClock,
   input  wire logic           cableMode,
   input  wire logic           compressEn,
   input  wire logic           reconfigPulseInstr,
   output pscl_cfg_word_t      cfgWord,
   output logic                cfgValid,
   input  wire logic           cfgReady
);
   localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

   pscl_state_t state_r;  // loader state
   logic [15:0] cnt_r;    // release delay and init tick counter
   logic        restart;  // request low or reconfiguration pulse
   logic        tick;     // one initialisation step

   initial begin
      if (BUF_W != 8 || BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0 ||
          IMAGE_BYTES < 1 || INIT_TICKS < 1 || IMAGE_BYTES >= (1 << CFG_ADDR_W))
         $error("pscl_loader: unsupported parameter values");
   end

   // ***************************************************************
   // link domain, rising edge of the bit clock
   // ***************************************************************
   logic       accS1_r, accS2_r;   // load window, synchronised to link
   logic       doneS1_r, doneS2_r; // own load done, for forwarding
   logic [6:0] shift_r;            // partial byte, LSB first
   logic [2:0] bitCnt_r;           // bits held in shift_r
   logic [7:0] byteHold_r;         // last complete byte
   logic       byteTog_r;          // flips once per byte
   logic       chainData_r;        // forwarded data bit

   // level crossing into link domain
   always_ff @(posedge configBitClock or negedge resetn) begin
      if (!resetn) begin
         accS1_r  <= 1'b0;
         accS2_r  <= 1'b0;
         doneS1_r <= 1'b0;
         doneS2_r <= 1'b0;
      end else begin
         accS1_r  <= (state_r == ST_LOAD);
         accS2_r  <= accS1_r;
         doneS1_r <= loadComplete;
         doneS2_r <= doneS1_r;
      end
   end

   // byte assembly; bits outside the load window are dropped
   always_ff @(posedge configBitClock or negedge resetn) begin
      if (!resetn) begin
         shift_r    <= 7'h00;
         bitCnt_r   <= BIT_RESET;
         byteHold_r <= 8'h00;
         byteTog_r  <= 1'b0;
      end else if (!accS2_r) begin
         bitCnt_r <= BIT_RESET;
      end else begin
         shift_r  <= {configData, shift_r[6:1]};
         bitCnt_r <= bitCnt_r + 3'h1;
         if (bitCnt_r == 3'h7) begin
            byteHold_r <= {configData, shift_r};   // first bit lands in bit 0
            byteTog_r  <= ~byteTog_r;
         end
      end
   end

   // after own load the stream passes on to the downstream devices
   always_ff @(posedge configBitClock or negedge resetn) begin
      if (!resetn) begin
         chainData_r <= 1'b0;
      end else begin
         chainData_r <= doneS2_r ? configData : 1'b0;
      end
   end
   assign chainData = chainData_r;

   // ***************************************************************
   // core domain: pin synchronisers
   // ***************************************************************
   logic [7:0] pinS1_r, pinS2_r; // two flops for every asynchronous input
   logic       usrPrev_r;        // last synchronised start-up clock
   logic       togPrev_r;        // last synchronised byte toggle
   logic       reqN, togS, bclkS, usrClk, useUsr, cable, compr, nceN;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinS1_r   <= 8'h00;
         pinS2_r   <= 8'h00;
         usrPrev_r <= 1'b0;
         togPrev_r <= 1'b0;
      end else begin
         pinS1_r   <= {configRequestN, byteTog_r, configBitClock,
                       userStartupClock, useStartupClock, cableMode, compressEn,
                       chainEnableInN};
         pinS2_r   <= pinS1_r;
         usrPrev_r <= pinS2_r[4];
         togPrev_r <= pinS2_r[6];
      end
   end
   assign {reqN, togS, bclkS, usrClk, useUsr, cable, compr, nceN} = pinS2_r;

   // ***************************************************************
   // core domain: the two initialisation edges
   // ***************************************************************
   // the bit clock is sampled here, so no edge is spent on a crossing;
   // a host that stops after two edges still starts initialisation
   logic       bclkPrev_r; // last synchronised bit clock
   logic       lcDly_r;    // load complete one cycle late, matches pin delay
   logic [1:0] fallCnt_r;  // falling edges since load complete
   logic       edgesDone;  // enough edges seen

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bclkPrev_r <= 1'b0;
         lcDly_r    <= 1'b0;
         fallCnt_r  <= FALL_RESET;
      end else begin
         bclkPrev_r <= bclkS;
         lcDly_r    <= loadComplete;
         // an edge that fell before load complete is not counted
         if (!lcDly_r)
            fallCnt_r <= FALL_RESET;
         else if (bclkPrev_r && !bclkS && fallCnt_r != 2'(EDGES_NEEDED))
            fallCnt_r <= fallCnt_r + 2'h1;
      end
   end
   assign edgesDone = (fallCnt_r == 2'(EDGES_NEEDED));

   // ***************************************************************
   // two-entry byte buffer between link and expander
   // ***************************************************************
   logic [BUF_W-1:0] bufMem [BUF_DEPTH]; // entries
   logic [PW-1:0]    wrPtr_r, rdPtr_r;
   logic [PW:0]      bufCnt_r;
   logic             pend_r;              // byte arrived, not yet stored
   logic             overflow;            // byte lost
   logic             inValid, inReady, outValid, outReady, newByte;
   logic [BUF_W-1:0] outByte;

   assign newByte  = togS ^ togPrev_r;
   assign inValid  = newByte | pend_r;
   assign inReady  = (bufCnt_r != (PW+1)'(BUF_DEPTH));
   assign outValid = (bufCnt_r != '0);
   assign outByte  = bufMem[rdPtr_r];
   // a byte still waiting when the next lands means the drain fell behind
   assign overflow = newByte & pend_r;

   // storage and pointers; a full buffer holds the byte in pend_r
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrPtr_r  <= '0;
         rdPtr_r  <= '0;
         bufCnt_r <= '0;
         pend_r   <= 1'b0;
      end else if (restart) begin
         wrPtr_r  <= '0;
         rdPtr_r  <= '0;
         bufCnt_r <= '0;
         pend_r   <= 1'b0;
      end else begin
         pend_r <= inValid & ~inReady;
         if (inValid && inReady)
            wrPtr_r <= wrPtr_r + PW'(1);
         if (outValid && outReady)
            rdPtr_r <= rdPtr_r + PW'(1);
         bufCnt_r <= bufCnt_r + (PW+1)'(inValid && inReady)
                              - (PW+1)'(outValid && outReady);
      end
   end

   always_ff @(posedge clk) begin
      if (inValid && inReady)
         bufMem[wrPtr_r] <= byteHold_r; // stable: toggle seen two flops later
   end

   // ***************************************************************
   // expander: escape byte then run length of fill bytes
   // ***************************************************************
   logic [7:0]            runLeft_r;  // fill bytes still to emit
   logic                  wantLen_r;  // escape seen, length next
   logic [CFG_ADDR_W-1:0] outCnt_r;   // bytes written to memory
   logic                  cfgValid_r;
   pscl_cfg_word_t        cfgWord_r;
   logic                  slot, emitFill, emitLit, takeEsc, takeLen, loadDone;

   assign slot     = (state_r == ST_LOAD) & ~loadDone & (~cfgValid_r | cfgReady);
   assign emitFill = slot & (runLeft_r != 8'h00);
   assign takeEsc  = slot & (runLeft_r == 8'h00) & outValid & ~wantLen_r & compr &
                     (outByte == RLE_ESCAPE);
   assign takeLen  = slot & (runLeft_r == 8'h00) & outValid & wantLen_r;
   assign emitLit  = slot & (runLeft_r == 8'h00) & outValid & ~takeEsc & ~takeLen;
   assign outReady = takeEsc | takeLen | emitLit;
   assign loadDone = (outCnt_r == CFG_ADDR_W'(IMAGE_BYTES));

   // run tracking; one expanded byte per core cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         runLeft_r <= 8'h00;
         wantLen_r <= 1'b0;
      end else if (restart) begin
         runLeft_r <= 8'h00;
         wantLen_r <= 1'b0;
      end else begin
         if (takeEsc)
            wantLen_r <= 1'b1;
         else if (takeLen)
            wantLen_r <= 1'b0;
         if (takeLen)
            runLeft_r <= outByte;
         else if (emitFill)
            runLeft_r <= runLeft_r - 8'h01;
      end
   end

   // memory write port, held until taken
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfgValid_r <= 1'b0;
         cfgWord_r  <= '0;
         outCnt_r   <= '0;
      end else if (restart) begin
         cfgValid_r <= 1'b0;
         outCnt_r   <= '0;
      end else begin
         if (emitFill || emitLit) begin
            cfgValid_r     <= 1'b1;
            cfgWord_r.addr <= outCnt_r;
            cfgWord_r.data <= emitFill ? FILL_BYTE : outByte;
            outCnt_r       <= outCnt_r + CFG_ADDR_W'(1);
         end else if (cfgReady) begin
            cfgValid_r <= 1'b0;
         end
      end
   end
   assign cfgValid = cfgValid_r;
   assign cfgWord  = cfgWord_r;

   // ***************************************************************
   // loader state machine
   // ***************************************************************
   // only a low request or the pulse restarts; new flash content does not
   assign restart = ~reqN | reconfigPulseInstr;
   // a cable build never waits for the user start-up clock
   assign tick    = (cable | ~useUsr) ? 1'b1 : (usrClk & ~usrPrev_r);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_HOLD;
         cnt_r   <= 16'h0000;
      end else if (restart) begin
         state_r <= ST_HOLD;
         cnt_r   <= 16'h0000;
      end else begin
         case (state_r)
            ST_HOLD: begin
               state_r <= ST_RELEASE;                          // request high again
               cnt_r   <= 16'h0000;
            end
            ST_RELEASE: begin
               if (cnt_r >= 16'(STATUS_CYC - 1) && !nceN)
                  state_r <= ST_LOAD;
               else if (cnt_r < 16'(STATUS_CYC - 1))
                  cnt_r <= cnt_r + 16'h0001;
            end
            ST_LOAD: begin
               if (overflow)
                  state_r <= ST_ERROR;
               else if (loadDone && !cfgValid_r)
                  state_r <= ST_EDGES;
            end
            ST_EDGES: begin
               cnt_r <= 16'h0000;
               if (edgesDone)
                  state_r <= ST_INIT;
            end
            ST_INIT: begin
               if (tick) begin
                  if (cnt_r == 16'(INIT_TICKS - 1))
                     state_r <= ST_USER;
                  else
                     cnt_r <= cnt_r + 16'h0001;
               end
            end
            ST_USER:  state_r <= ST_USER;
            ST_ERROR: state_r <= ST_ERROR;                     // held until restart
            default:  state_r <= ST_HOLD;
         endcase
      end
   end

   // ***************************************************************
   // pin outputs, all registered
   // ***************************************************************
   logic statN_r, lc_r, idone_r, pull_r, ceo_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         statN_r <= 1'b0;
         lc_r    <= 1'b0;
         idone_r <= 1'b0;
         pull_r  <= 1'b1;
         ceo_r   <= 1'b1;
      end else begin
         statN_r <= ~restart & (state_r != ST_HOLD) & (state_r != ST_RELEASE) &
                    (state_r != ST_ERROR);
         lc_r    <= ~restart & ((state_r == ST_EDGES) | (state_r == ST_INIT) |
                                (state_r == ST_USER));
         idone_r <= ~restart & (state_r == ST_USER);
         pull_r  <= restart | (state_r != ST_USER);
         ceo_r   <= ~lc_r;
      end
   end
   // status is active low: low while held, releasing, or failed
   assign configStatusN   = statN_r;
   assign loadComplete    = lc_r;
   assign initDone        = idone_r;
   assign weakPullupEn    = pull_r;
   assign chainEnableOutN = ceo_r;

   // ***************************************************************
   // checks
   // ***************************************************************
   AST_ACCEPT_AFTER_STATUS: assert property (@(posedge clk) disable iff (!resetn)
      (outReady || emitFill) |-> configStatusN)
      else $error("data taken while status low");
   AST_LOAD_DONE: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == ST_LOAD && loadDone && !cfgValid_r && !overflow && !restart)
      |=> ##1 loadComplete)
      else $error("load complete not raised");
   AST_INIT_AFTER_EDGES: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == ST_EDGES && !edgesDone && !restart) |=> state_r == ST_EDGES)
      else $error("init started without edges");
   AST_EDGE_STEP: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == ST_EDGES && edgesDone && !restart) |=> state_r == ST_INIT)
      else $error("edges seen but init not entered");
   AST_USER_RISE: assert property (@(posedge clk) disable iff (!resetn)
      $rose(initDone) |-> $past(state_r) == ST_USER && $past(state_r, 2) != ST_HOLD)
      else $error("init done rose outside user mode");
   AST_PULLUPS: assert property (@(posedge clk) disable iff (!resetn)
      weakPullupEn != initDone)
      else $error("pull-ups not tied to user mode");
   AST_FILL: assert property (@(posedge clk) disable iff (!resetn)
      (emitFill && !restart) |=> cfgValid && cfgWord.data == FILL_BYTE)
      else $error("run did not expand to fill bytes");
   AST_CHAIN_HIGH: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == ST_LOAD) ##1 (state_r == ST_LOAD) |-> chainEnableOutN)
      else $error("chain enable low during own load");
   AST_CHAIN_LOW: assert property (@(posedge clk) disable iff (!resetn)
      loadComplete ##1 loadComplete |-> !chainEnableOutN)
      else $error("chain enable high after load");
   AST_CABLE_INIT: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == ST_INIT && cable && !restart && cnt_r != 16'(INIT_TICKS - 1))
      |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("cable init waited for start-up clock");
   AST_RECONFIG: assert property (@(posedge clk) disable iff (!resetn)
      reconfigPulseInstr |=> state_r == ST_HOLD ##1 !initDone && weakPullupEn)
      else $error("reconfiguration pulse did not reset loader");
endmodule

// ### pscl_pkg.sv
package pscl_pkg;
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS   = 8;   // core clock period
   localparam int STATUS_DELAY_NS = 40;  // least time status stays low after request
   localparam int STATUS_CYC      = (STATUS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_TICKS_DEF  = 64;  // default initialisation length in ticks
   localparam int IMAGE_BYTES_DEF = 1024; // default expanded image size in bytes
   localparam int EDGES_NEEDED    = 2;   // falling bit-clock edges after load complete

   // ***************************************************************
   // encodings and reset values
   // ***************************************************************
   localparam logic [7:0] RLE_ESCAPE   = 8'h00; // marks a zero run, next byte is length
   localparam logic [7:0] FILL_BYTE    = 8'h00; // value a run expands to
   localparam int         CFG_ADDR_W   = 24;    // config memory address width
   localparam logic [1:0] FALL_RESET   = 2'h0;
   localparam logic [2:0] BIT_RESET    = 3'h0;

   // loader states, gray along the normal path
   typedef enum logic [2:0] {
      ST_HOLD    = 3'b000,
      ST_RELEASE = 3'b001,
      ST_LOAD    = 3'b011,
      ST_EDGES   = 3'b010,
      ST_INIT    = 3'b110,
      ST_USER    = 3'b111,
      ST_ERROR   = 3'b101
   } pscl_state_t;

   // one expanded word for the configuration memory
   typedef struct packed {
      logic [CFG_ADDR_W-1:0] addr;
      logic [7:0]            data;
   } pscl_cfg_word_t;
endpackage

// ### pscl_host_model.sv
// ***************************************
// host that drives the serial link
// ***************************************
module pscl_host_model (
   output logic      configRequestN,  // request, low holds device in reset
   output logic      configBitClock,  // bit clock, still outside frames
   output logic      configData,      // serial data line
   input  wire logic configStatusN    // device ready when high
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam real HALF = 40.0;       // half of the 80 ns bit period

   // idle levels from time zero
   initial begin
      configRequestN = 1'b0;
      configBitClock = 1'b0;
      configData     = 1'b0;
   end

   // bare clock pulses, data line left alone
   task automatic pulse(input int n);
      #3.3; // keeps link edges off the core clock grid
      repeat (n) begin
         #HALF configBitClock = 1'b1;
         #HALF configBitClock = 1'b0;
      end
   endtask

   // one byte, lsb first, data changed while clock is low
   task automatic send_byte(input logic [7:0] b);
      #3.3;
      for (int i = 0; i < 8; i++) begin
         configData = b[i];
         #HALF configBitClock = 1'b1;
         #HALF configBitClock = 1'b0;
      end
      configData = ~configData; // released line must not look stable
   endtask

   // request edge, bounded wait for ready, then two sync pulses
   task automatic start(output bit ok);
      configRequestN = 1'b0;
      #400 configRequestN = 1'b1;
      ok = 1'b0;
      for (int k = 0; k < 200 && !ok; k++) begin
         #8 ok = (configStatusN === 1'b1);
      end
      if (ok) pulse(2); // the link window needs two edges to open
   endtask
endmodule

// ### pscl_tb_top.sv
`define CHK(nm, exp, got) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
   end \
end
`define WAITF(c, n) for (int k = 0; k < (n) && !(c); k++) @(negedge clk);

module tb_top
   import pscl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ***************************************
   // signals
   // ***************************************
   localparam int  TMO = 30000;        // cycle ceiling, run needs far less
   logic           clk, resetn;        // core clock and reset
   logic           configRequestN, configStatusN, configBitClock, configData;
   logic           loadComplete, initDone, weakPullupEn;
   logic           chainEnableInN, chainEnableOutN, chainData;
   logic           userStartupClock, useStartupClock, cableMode, compressEn;
   logic           reconfigPulseInstr, cfgValid, cfgReady;
   pscl_cfg_word_t cfgWord;            // word to configuration memory
   pscl_cfg_word_t words [$];          // words taken by the memory side
   int             mismatches, cmp_count, cycles;
   logic [7:0]     plainImg [8]    = '{8'h02, 8'h1b, 8'hee, 8'h01,
                                       8'hfa, 8'h00, 8'h03, 8'h7e};
   logic [7:0]     packedImg [9]   = '{8'h5a, 8'h00, 8'h03, 8'hc3, 8'h00,
                                       8'h00, 8'h11, 8'h22, 8'h33};
   logic [7:0]     expandedImg [8] = '{8'h5a, 8'h00, 8'h00, 8'h00,
                                       8'hc3, 8'h11, 8'h22, 8'h33};

   // small image and short init keep the run brief
   pscl_loader #(.IMAGE_BYTES(8), .INIT_TICKS(4)) dut (
      .clk(clk), .resetn(resetn), .configRequestN(configRequestN),
      .configStatusN(configStatusN), .configBitClock(configBitClock),
      .configData(configData), .loadComplete(loadComplete), .initDone(initDone),
      .weakPullupEn(weakPullupEn), .chainEnableInN(chainEnableInN),
      .chainEnableOutN(chainEnableOutN), .chainData(chainData),
      .userStartupClock(userStartupClock), .useStartupClock(useStartupClock),
      .cableMode(cableMode), .compressEn(compressEn),
      .reconfigPulseInstr(reconfigPulseInstr), .cfgWord(cfgWord),
      .cfgValid(cfgValid), .cfgReady(cfgReady));

   pscl_host_model host (
      .configRequestN(configRequestN), .configBitClock(configBitClock),
      .configData(configData), .configStatusN(configStatusN));

   // ***************************************
   // clock, collector, watchdog
   // ***************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // record every word the memory side accepts
   always @(posedge clk) begin
      if (cfgValid === 1'b1 && cfgReady === 1'b1) words.push_back(cfgWord);
   end

   // a hang counts as a mismatch and closes the run
   always @(posedge clk) begin
      cycles++;
      if (cycles == TMO) begin
         mismatches++;
         results();
      end
   end

   task automatic results;
      if (mismatches == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // words must arrive at rising addresses with the expected bytes
   task automatic check_words(input logic [7:0] exp [8]);
      `CHK("word count", 8, words.size())
      for (int i = 0; i < words.size() && i < 8; i++) begin
         `CHK("addr", 24'(i), words[i].addr)
         `CHK("data", exp[i], words[i].data)
      end
   endtask

   // strap pins for one scenario: cable, start-up clock option, expansion
   task automatic set_mode(input logic cab, input logic usr, input logic cmp);
      cableMode       = cab;
      useStartupClock = usr;
      compressEn      = cmp;
   endtask

   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_reset;
      `CHK("status", 1'b0, configStatusN)
      `CHK("init done", 1'b0, initDone)
      `CHK("pull-ups", 1'b1, weakPullupEn)
      `CHK("chain out", 1'b1, chainEnableOutN)
      host.send_byte(8'hff); // no request yet, must be dropped
      repeat (20) @(negedge clk);
      `CHK("early valid", 1'b0, cfgValid)
   endtask

   // cable load with a stalling memory side
   task automatic t_plain;
      bit ok;
      set_mode(1'b1, 1'b1, 1'b0); // option set, cable must override it
      fork
         host.start(ok);
         begin
            repeat (70) @(negedge clk); // request is high, chain input still high
            `CHK("held off", 1'b0, configStatusN)
            chainEnableInN = 1'b0;
         end
      join
      fork
         foreach (plainImg[i]) host.send_byte(plainImg[i]);
         begin
            repeat (150) @(negedge clk);
            cfgReady = 1'b1; // stall covers almost two bytes
         end
      join
      @(negedge clk);
      `CHK("chain out loading", 1'b1, chainEnableOutN)
      `CHK("chain data loading", 1'b0, chainData)
      `WAITF(loadComplete, 60)
      `CHK("load complete", 1'b1, loadComplete)
      `CHK("no error", 1'b1, configStatusN)
      `WAITF(!chainEnableOutN, 4)
      `CHK("chain out", 1'b0, chainEnableOutN)
      check_words(plainImg);
      `CHK("init early", 1'b0, initDone)
      host.pulse(2);
      @(negedge clk);
      `WAITF(initDone, 40)
      `CHK("init done", 1'b1, initDone)
      @(negedge clk);
      `CHK("pull-ups", 1'b0, weakPullupEn)
      // after own load every further bit is passed on to the slaves
      fork
         host.send_byte(8'h81);
         begin
            #60 `CHK("chain bit0", 1'b1, chainData)
            #80 `CHK("chain bit1", 1'b0, chainData)
         end
      join
      @(negedge clk);
   endtask

   // reconfig pulse, then compressed load, init timed by the user clock
   task automatic t_packed;
      bit ok;
      reconfigPulseInstr = 1'b1;
      @(negedge clk);
      reconfigPulseInstr = 1'b0;
      repeat (3) @(negedge clk);
      `CHK("init after pulse", 1'b0, initDone)
      `CHK("load after pulse", 1'b0, loadComplete)
      `CHK("chain after pulse", 1'b1, chainEnableOutN)
      words.delete();
      set_mode(1'b0, 1'b1, 1'b1);
      host.start(ok);
      foreach (packedImg[i]) host.send_byte(packedImg[i]);
      @(negedge clk);
      `WAITF(loadComplete, 60)
      check_words(expandedImg);
      host.pulse(2);
      repeat (60) @(negedge clk);
      `CHK("init without ticks", 1'b0, initDone)
      repeat (20) begin
         repeat (2) @(negedge clk);
         userStartupClock = ~userStartupClock;
      end
      `CHK("init by user clock", 1'b1, initDone)
   endtask

   // buffer overrun while memory stalls, host restarts
   task automatic t_overflow;
      bit ok;
      set_mode(1'b0, 1'b1, 1'b0);
      cfgReady = 1'b0;
      host.start(ok);
      repeat (6) host.send_byte(8'h55);
      @(negedge clk);
      `WAITF(!configStatusN, 20)
      `CHK("overflow", 1'b0, configStatusN)
      host.start(ok);
      @(negedge clk);
      words.delete();
      cfgReady = 1'b1;
      `CHK("no stale word", 1'b0, cfgValid)
      host.send_byte(8'ha5);
      @(negedge clk);
      `WAITF(words.size() > 0, 20)
      `CHK("restart addr", 24'h000000, words[0].addr)
      `CHK("restart data", 8'ha5, words[0].data)
   endtask

   // ***************************************
   // main sequence
   // ***************************************
   initial begin
      resetn = 1'b0;
      cfgReady = 1'b0;
      chainEnableInN = 1'b1;
      userStartupClock = 1'b0;
      set_mode(1'b0, 1'b0, 1'b0);
      reconfigPulseInstr = 1'b0;
      // two full rising edges in reset, release on a falling edge
      repeat (2) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      t_reset();
      t_plain();
      t_packed();
      t_overflow();
      results();
   end
endmodule
